// file: core/bidio_ports.sv

`timescale 1ns/1ps
`default_nettype none
module bidio_ports (
  input  wire logic                          CLK_SYS,
  input  wire logic                          ARST_N,
  input  wire logic [bidio_pkg::BIDIO_AW-1:0] ADDR,
  input  wire logic                          WR_EN,
  input  wire logic                          RD_EN,
  input  wire logic [bidio_pkg::BIDIO_W-1:0]  WDATA,
  output var  logic [bidio_pkg::BIDIO_W-1:0]  RDATA,
  input  wire logic [bidio_pkg::BIDIO_W-1:0]  PORT_A_IN,
  output var  logic [bidio_pkg::BIDIO_W-1:0]  PORT_A_OUT,
  output var  logic [bidio_pkg::BIDIO_W-1:0]  PORT_A_OE,
  input  wire logic [bidio_pkg::BIDIO_W-1:0]  PORT_B_IN,
  output var  logic [bidio_pkg::BIDIO_W-1:0]  PORT_B_OUT,
  output var  logic [bidio_pkg::BIDIO_W-1:0]  PORT_B_OE,
  input  wire logic [bidio_pkg::BIDIO_W-1:0]  PORT_C_IN,
  output var  logic [bidio_pkg::BIDIO_W-1:0]  PORT_C_OUT,
  output var  logic [bidio_pkg::BIDIO_W-1:0]  PORT_C_OE,
  input  wire logic [bidio_pkg::BIDIO_W-1:0]  PORT_D_IN,
  input  wire logic                          INT_PIN_N,
  output var  logic                          INT_LEVEL
);
  import bidio_pkg::*;

  localparam int unsigned NP = BIDIO_NUM_BIDIR;

  logic [NP-1:0][BIDIO_W-1:0] dir_reg;
  logic [NP-1:0][BIDIO_W-1:0] dir_next;
  logic [NP-1:0][BIDIO_W-1:0] latch_reg;
  logic [NP-1:0][BIDIO_W-1:0] latch_next;
  logic [BIDIO_W-1:0]         rdata_reg;
  logic [BIDIO_W-1:0]         rdata_next;
  logic [NP-1:0][BIDIO_W-1:0] oe_reg;
  logic [NP-1:0][BIDIO_W-1:0] oe_next;
  logic [NP-1:0][BIDIO_W-1:0] out_reg;
  logic [NP-1:0][BIDIO_W-1:0] out_next;
  logic                       int_level_reg;
  logic                       int_level_next;
  logic [BIDIO_W-1:0]         pin_a_sync;
  logic [BIDIO_W-1:0]         pin_b_sync;
  logic [BIDIO_W-1:0]         pin_c_sync;
  logic [NP-1:0][BIDIO_W-1:0] pin_sync;
  logic [BIDIO_W-1:0]         pin_d_sync;
  logic [0:0]                 int_active;
  logic [NP-1:0]              data_sel;
  logic [NP-1:0]              dir_sel;
  logic                       d_sel;

  bidio_sync #(.W(BIDIO_W)) u_sync_a (
    .clk    (CLK_SYS),
    .arst_n (ARST_N),
    .d      (PORT_A_IN),
    .q      (pin_a_sync)
  );

  bidio_sync #(.W(BIDIO_W)) u_sync_b (
    .clk    (CLK_SYS),
    .arst_n (ARST_N),
    .d      (PORT_B_IN),
    .q      (pin_b_sync)
  );

  bidio_sync #(.W(BIDIO_W)) u_sync_c (
    .clk    (CLK_SYS),
    .arst_n (ARST_N),
    .d      (PORT_C_IN),
    .q      (pin_c_sync)
  );

  bidio_sync #(.W(BIDIO_W)) u_sync_d (
    .clk    (CLK_SYS),
    .arst_n (ARST_N),
    .d      (PORT_D_IN),
    .q      (pin_d_sync)
  );

  // Inverted pin so the synchroniser's reset value matches an idle high pin
  bidio_sync #(.W(1)) u_sync_int (
    .clk    (CLK_SYS),
    .arst_n (ARST_N),
    .d      (~INT_PIN_N),
    .q      (int_active)
  );

  assign pin_sync = {pin_c_sync, pin_b_sync, pin_a_sync};

  // Per bit: output bits read the latch, input bits read the pin
  function automatic logic [BIDIO_W-1:0] port_view(
    input logic [BIDIO_W-1:0] dir,
    input logic [BIDIO_W-1:0] latch,
    input logic [BIDIO_W-1:0] pin
  );
    port_view = (dir & latch) | (~dir & pin);
  endfunction : port_view

  // One decode serves both paths, so the read and write maps cannot drift apart
  function automatic logic [NP-1:0] port_hit(
    input logic [BIDIO_AW-1:0] addr,
    input logic [BIDIO_AW-1:0] base
  );
    port_hit = '0;
    for (int p = 0; p < NP; p++) begin
      port_hit[p] = (addr == base + BIDIO_AW'(p));
    end
  endfunction : port_hit

  always_comb begin
    data_sel = port_hit(ADDR, BIDIO_ADDR_PORT_A_DATA);
    dir_sel  = port_hit(ADDR, BIDIO_ADDR_PORT_A_DIR);
    // Port D has no direction register, so it decodes only as data
    d_sel    = (ADDR == BIDIO_ADDR_PORT_D_DATA);
  end

  // Write path: one store replaces a whole register, with no per-bit merge
  always_comb begin
    dir_next   = dir_reg;
    latch_next = latch_reg;
    for (int p = 0; p < NP; p++) begin
      if (WR_EN && data_sel[p]) begin
        latch_next[p] = WDATA;
      end
      if (WR_EN && dir_sel[p]) begin
        dir_next[p] = WDATA;
      end
    end
  end

  // Read path sees register values from before a write in the same cycle
  always_comb begin
    rdata_next = rdata_reg;
    if (RD_EN) begin
      rdata_next = BIDIO_UNMAPPED_READ;
      for (int p = 0; p < NP; p++) begin
        if (data_sel[p]) begin
          rdata_next = port_view(dir_reg[p], latch_reg[p], pin_sync[p]);
        end
        if (dir_sel[p]) begin
          rdata_next = BIDIO_DIR_READBACK;
        end
      end
      if (d_sel) begin
        rdata_next = pin_d_sync;
      end
    end
  end

  // The direction bits decide who drives the pins, so unlike the latches they take reset
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      dir_reg <= {NP{BIDIO_DIR_RESET}};
    end else begin
      dir_reg <= dir_next;
    end
  end

  // Read data holds between reads so a slow poll sees a steady byte
  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_reg <= BIDIO_UNMAPPED_READ;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // Latches sit outside the reset on purpose so software sees no implied value
  always_ff @(posedge CLK_SYS) begin
    latch_reg <= latch_next;
  end

  // Drivers follow next state so they switch at the edge that takes the write
  always_comb begin
    oe_next  = dir_next;
    out_next = '0;
    for (int p = 0; p < NP; p++) begin
      out_next[p] = latch_next[p] & dir_next[p];
    end
    int_level_next = ~int_active[0];
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N) begin
    if (!ARST_N) begin
      oe_reg        <= '0;
      out_reg       <= '0;
      // Idle high, so no false interrupt level shows right after reset
      int_level_reg <= 1'b1;
    end else begin
      oe_reg        <= oe_next;
      out_reg       <= out_next;
      int_level_reg <= int_level_next;
    end
  end

  // Every output comes straight from a flop
  assign PORT_A_OUT = out_reg[0];
  assign PORT_A_OE  = oe_reg[0];
  assign PORT_B_OUT = out_reg[1];
  assign PORT_B_OE  = oe_reg[1];
  assign PORT_C_OUT = out_reg[2];
  assign PORT_C_OE  = oe_reg[2];
  assign RDATA      = rdata_reg;
  assign INT_LEVEL  = int_level_reg; // 24 bidir + 8 input pins
endmodule : bidio_ports
`default_nettype wire

// file: core/bidio_pkg.sv
package bidio_pkg;
  localparam int unsigned BIDIO_W = 8;
  localparam int unsigned BIDIO_AW = 13;
  // Data registers at the bottom of page zero, direction registers just above
  localparam logic [12:0] BIDIO_ADDR_PORT_A_DATA = 13'h0000;
  localparam logic [12:0] BIDIO_ADDR_PORT_B_DATA = 13'h0001;
  localparam logic [12:0] BIDIO_ADDR_PORT_C_DATA = 13'h0002;
  localparam logic [12:0] BIDIO_ADDR_PORT_D_DATA = 13'h0003;
  localparam logic [12:0] BIDIO_ADDR_PORT_A_DIR  = 13'h0004;
  localparam logic [12:0] BIDIO_ADDR_PORT_B_DIR  = 13'h0005;
  localparam logic [12:0] BIDIO_ADDR_PORT_C_DIR  = 13'h0006;
  localparam logic [7:0]  BIDIO_DIR_RESET        = 8'h00;
  localparam logic [7:0]  BIDIO_DIR_READBACK     = 8'hff;
  localparam logic [7:0]  BIDIO_UNMAPPED_READ    = 8'h00;
  localparam int unsigned BIDIO_NUM_BIDIR        = 3;
  localparam int unsigned BIDIO_TOTAL_PINS       = 32;
endpackage : bidio_pkg

// file: core/bidio_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; a change is accepted once stages two and three agree
module bidio_sync #(
  parameter int unsigned W = 8
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_reg;
  logic [W-1:0] q_next;

  always_comb begin
    for (int i = 0; i < W; i++) begin
      q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_reg <= '0;
      s2_reg <= '0;
      s3_reg <= '0;
      q_reg  <= '0;
    end else begin
      s1_reg <= d;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign q = q_reg;
endmodule : bidio_sync
`default_nettype wire

// file: dv/bidio_ports_props.sv
`timescale 1ns/1ps
`default_nettype none
module bidio_ports_props (
  input wire logic CLK_SYS,
  input wire logic ARST_N,
  input wire logic [bidio_pkg::BIDIO_AW-1:0] ADDR,
  input wire logic WR_EN,
  input wire logic RD_EN,
  input wire logic [bidio_pkg::BIDIO_W-1:0] WDATA,
  input wire logic [bidio_pkg::BIDIO_W-1:0] RDATA,
  input wire logic [bidio_pkg::BIDIO_W-1:0] PORT_A_OUT,
  input wire logic [bidio_pkg::BIDIO_W-1:0] PORT_A_OE,
  input wire logic [bidio_pkg::BIDIO_W-1:0] PORT_B_OE,
  input wire logic [bidio_pkg::BIDIO_W-1:0] PORT_C_OE
);
  import bidio_pkg::*;
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!ARST_N);
  chk_input_undriven: assert property ((PORT_A_OUT & ~PORT_A_OE) == 8'h00)
    else $error("input bit driven");
  chk_dir_a_load: assert property (WR_EN && ADDR == 13'h004 |=> PORT_A_OE == $past(WDATA))
    else $error("dir A");
  chk_dir_b_load: assert property (WR_EN && ADDR == 13'h005 |=> PORT_B_OE == $past(WDATA))
    else $error("dir B");
  chk_dir_c_load: assert property (WR_EN && ADDR == 13'h006 |=> PORT_C_OE == $past(WDATA))
    else $error("dir C");
  chk_dir_reads_ones: assert property (
    RD_EN && ADDR inside {[13'h004:13'h006]} |=> RDATA == 8'hff) else $error("dir readback");
  chk_latch_all_bits: assert property (
    WR_EN && ADDR == 13'h000 && PORT_A_OE == 8'hff |=> PORT_A_OUT == $past(WDATA))
    else $error("latch A");
  chk_read_latch: assert property (
    RD_EN && ADDR == 13'h000 && PORT_A_OE == 8'hff |=> RDATA == $past(PORT_A_OUT))
    else $error("read latch");
  chk_rdata_holds: assert property (!RD_EN |=> $stable(RDATA))
    else $error("read data moved");
endmodule : bidio_ports_props
bind bidio_ports bidio_ports_props u_props (.*);
`default_nettype wire

// file: dv/bidio_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module bidio_pin_model (
  input  wire logic [7:0] out,
  input  wire logic [7:0] oe,
  input  wire logic [7:0] ext,
  input  wire logic       load,
  output wire logic [7:0] pin
);
  // A heavy load overrides the driver, so a pin read cannot mimic the latch
  assign pin = load ? ext : (oe & out) | (~oe & ext);
endmodule : bidio_pin_model
`default_nettype wire

// file: dv/test_bidio_ports.sv
`timescale 1ns/1ps
`default_nettype none
module test_bidio_ports;
  import bidio_pkg::*;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, ld = 0, intp = 1, il;
  logic [12:0] addr = 0;
  logic [7:0] wd = 0, rdat, d_in = 0, po [3], pe [3];
  logic [7:0] ext [3] = '{8'h00, 8'h00, 8'h00};
  wire [7:0] pi [3];
  int n_mismatch = 0, samples_checked = 0;
  initial forever #4 clk = ~clk;
  bidio_ports DUT (.CLK_SYS(clk), .ARST_N(rst_n), .ADDR(addr), .WR_EN(wr), .RD_EN(rd),
    .WDATA(wd), .RDATA(rdat), .PORT_A_IN(pi[0]), .PORT_A_OUT(po[0]), .PORT_A_OE(pe[0]),
    .PORT_B_IN(pi[1]), .PORT_B_OUT(po[1]), .PORT_B_OE(pe[1]), .PORT_C_IN(pi[2]),
    .PORT_C_OUT(po[2]), .PORT_C_OE(pe[2]), .PORT_D_IN(d_in), .INT_PIN_N(intp), .INT_LEVEL(il));
  for (genvar g = 0; g < 3; g++) begin : g_pin
    bidio_pin_model u_pin (.out(po[g]), .oe(pe[g]), .ext(ext[g]), .load(ld), .pin(pi[g]));
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // Leading idle cycle keeps a strobe from being lowered and raised in one step
  task automatic wr_b(input logic [12:0] a, input logic [7:0] d);
    cyc(1);
    {addr, wd, wr} = {a, d, 1'b1};
    cyc(1);
    wr = 0;
  endtask : wr_b
  task automatic rd_c(input logic [12:0] a, input logic [7:0] exp);
    cyc(1);
    {addr, rd} = {a, 1'b1};
    cyc(1);
    rd = 0;
    chk(rdat, exp);
  endtask : rd_c
  task automatic report_and_stop;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    cyc(2);
    rst_n = 1;
    chk(pe[0] | pe[1] | pe[2], 8'h00);
    chk({7'h00, il}, 8'h01);
    wr_b(13'h000, 8'h5a);
    wr_b(13'h004, 8'hff);
    rst_n = 0;
    cyc(1);
    rst_n = 1;
    chk(pe[0], 8'h00);
    wr_b(13'h004, 8'hff);
    rd_c(13'h000, 8'h5a);
    ld = 1;
    for (int p = 0; p < 3; p++) begin
      ext[p] = 8'h3c;
      wr_b(13'(p), 8'h96);
      wr_b(13'h004 + 13'(p), 8'hf0);
      chk(pe[p], 8'hf0);
      chk(po[p], 8'h90);
      cyc(5);
      rd_c(13'(p), 8'h9c);
    end
    for (int a = 4; a < 7; a++) rd_c(13'(a), 8'hff);
    d_in = 8'ha5;
    wr_b(13'h003, 8'h00);
    cyc(4);
    rd_c(13'h003, 8'ha5);
    rd_c(13'h0100, BIDIO_UNMAPPED_READ);
    intp = 0;
    cyc(6);
    chk({7'h00, il}, 8'h00);
    intp = 1;
    cyc(6);
    chk({7'h00, il}, 8'h01);
    report_and_stop();
  end
endmodule : test_bidio_ports
`default_nettype wire
